// ===== hdl/gtc_defines.svh
/*
 * Register offsets, field positions, reset values and timing figures of the
 * gated 16-bit timer/counter. Assumes inclusion by bare name.
 */
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte addresses (one aligned 32-bit word each)
// ----------------------------------------------------------------------------
`define GTC_ADDR_W          4
`define GTC_OFF_CTRL        4'h0
`define GTC_OFF_COUNT_LOW   4'h4
`define GTC_OFF_COUNT_HIGH  4'h8
`define GTC_OFF_IRQ         4'hC

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define GTC_CTRL_TIMER_ON   0
`define GTC_CTRL_CLK_SRC    1
`define GTC_CTRL_SYNC_DIS   2
`define GTC_CTRL_OSC_EN     3
`define GTC_CTRL_PS_LO      4
`define GTC_CTRL_PS_HI      5
`define GTC_CTRL_GATE_EN    6
`define GTC_CTRL_GATE_INV   7
`define GTC_CTRL_ALT_CLK    8
`define GTC_CTRL_GATE_SEL   9
`define GTC_CTRL_W          10
`define GTC_CTRL_RESET      10'h000

// ----------------------------------------------------------------------------
// Interrupt register fields
// ----------------------------------------------------------------------------
`define GTC_IRQ_FLAG        0
`define GTC_IRQ_OVF_EN      1
`define GTC_IRQ_PERIPH_EN   2
`define GTC_IRQ_GLOBAL_EN   3
`define GTC_IRQ_W           4
`define GTC_IRQ_RESET       4'h0

// ----------------------------------------------------------------------------
// Counter and timing
// ----------------------------------------------------------------------------
`define GTC_COUNT_RESET     16'h0000
`define GTC_COUNT_MAX       16'hFFFF
`define GTC_WAKE_VECTOR     16'h0004
`define GTC_CLK_HZ          20000000
`define GTC_LPOSC_HZ        32768
`define GTC_ICLK_DIV        4

`endif

// ===== hdl/gtc_pkg.sv
/*
 * Types of the gated 16-bit timer/counter.
 * Assumes gtc_defines.svh is compiled with it.
 */
package gtc_pkg;
	// ------------------------------------------------------------------------
	// Clock source selection and prescale codes
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		GTC_SRC_ICLK = 3'b001,
		GTC_SRC_SCLK = 3'b010,
		GTC_SRC_EXT  = 3'b100
	} gtc_src_e;

	typedef enum logic [1:0] {
		GTC_PS_DIV1 = 2'b00,
		GTC_PS_DIV2 = 2'b01,
		GTC_PS_DIV4 = 2'b10,
		GTC_PS_DIV8 = 2'b11
	} gtc_ps_e;

	// External edge arming: a falling edge must be seen before counting
	typedef enum logic [1:0] {
		GTC_ARM_WAIT_FALL = 2'b01,
		GTC_ARM_READY     = 2'b10
	} gtc_arm_e;
endpackage : gtc_pkg

// ===== hdl/gtc_timer.sv
/*
 * Gated 16-bit timer/counter with prescaler, external input, gate,
 * oscillator pin control, overflow flag, wake and special event clear.
 * Assumes a classic Wishbone master on clock; pins are asynchronous.
 */
// Added by the designer: the Wishbone register port and the register offsets.
// Functional notes
// RQ1: 16-bit up-counter in two bytes; byte writes replace the live count.
// RQ2: Source 0/alt 0 instruction clock, 0/1 system clock, 1 external pin.
// RQ3: External source counts rising edges, synchronised or asynchronous.
// RQ4: Counter mode needs a falling edge before the first counted rise.
// RQ5: Hidden prescale counter divides by 1,2,4,8; cleared by count writes.
// RQ6: Low-power oscillator enable selects oscillator source; runs in sleep.
// RQ7: Oscillator enabled forces pin directions input, pins read 0.
// RQ8: Software waits for oscillator start-up before turning the timer on.
// RQ9: Sync-disable counts unsynchronised, keeps counting in sleep, may wake; the counter still counts synchronised edges.
// RQ10: Mode switches may lose or add one count.
// RQ11: No capture/compare time base in async mode or alternate clock.
// RQ12: Async byte reads return a stable value.
// RQ13: Software stops the timer before writing count bytes.
// RQ14: Gate from pin or comparator, only when gate enable set.
// RQ15: Gate invert applies to either gate source.
// RQ16: Invert 1 counts gate high, 0 gate low; gate off runs freely.
// RQ17: Prescale field 00 /1, 01 /2, 10 /4, 11 /8.
// RQ18: Count only while timer on; gate enable ignored when off.
// RQ19: Rollover FFFF to 0000 sets overflow flag regardless of enables.
// RQ20: Interrupt only with all three enables; flag stays until cleared.
// RQ21: Async counter overflow in sleep wakes core, vector when global set.
// RQ22: Count feeds capture and compare; compare fires on equality.
// RQ23: Special event trigger clears count without setting overflow flag.
// RQ24: Count write in same cycle as trigger wins over the clear.
`include "gtc_defines.svh"

module gtc_timer #(
	parameter int COUNT_W = 16
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	input  wire logic        external_count_input,
	input  wire logic        lp_osc_clock,
	input  wire logic        gate_input_pin,
	input  wire logic        comparator_output,
	input  wire logic        sys_clk_internal,
	input  wire logic        sleep_mode,
	input  wire logic        capture_event,
	input  wire logic [15:0] compare_value,
	input  wire logic        special_event_trigger,
	output logic [15:0]      capture_value,
	output logic             compare_match,
	output logic             time_base_valid,
	output logic             pin5_direction,
	output logic             pin4_direction,
	output logic             port_pin_read_mask,
	output logic             overflow_irq,
	output logic             wake_request,
	output logic             wake_vector_taken
);
	initial begin
		if (COUNT_W != 16) $error("gtc_timer: COUNT_W must be 16");
	end

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	logic [1:0] ext_sync_q;
	logic [1:0] osc_sync_q;
	logic [1:0] gpin_sync_q;
	logic [1:0] cmp_sync_q;
	logic       ext_prev_q;
	logic       ext_level;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ext_sync_q  <= 2'b00;
			osc_sync_q  <= 2'b00;
			gpin_sync_q <= 2'b00;
			cmp_sync_q  <= 2'b00;
			ext_prev_q  <= 1'b0;
		end else if (clk_en) begin
			ext_sync_q  <= {ext_sync_q[0], external_count_input};
			osc_sync_q  <= {osc_sync_q[0], lp_osc_clock};
			gpin_sync_q <= {gpin_sync_q[0], gate_input_pin};
			cmp_sync_q  <= {cmp_sync_q[0], comparator_output};
			ext_prev_q  <= ext_level;
		end
	end

	// ------------------------------------------------------------------------
	// Control state
	// ------------------------------------------------------------------------
	logic [`GTC_CTRL_W-1:0] ctrl_q;
	logic [`GTC_IRQ_W-1:0]  irq_q;
	logic [15:0]            count_q;
	logic [2:0]             presc_q;
	logic [1:0]             iclk_q;
	gtc_pkg::gtc_arm_e      arm_q;
	logic                   timer_on_prev_q;

	logic       timer_on;
	logic       osc_en;
	logic       sync_dis;
	logic       gate_level;
	logic       gate_active;
	logic       src_tick;
	logic       run;
	logic       inc;
	logic       presc_done;
	logic       wr_low;
	logic       wr_high;
	logic       wr_count;
	logic       wr_ctrl;
	logic       wr_irq;
	logic       bus_req;
	logic       addr_hit;
	logic       rise;
	logic       fall;
	gtc_pkg::gtc_src_e src;

	assign timer_on = ctrl_q[`GTC_CTRL_TIMER_ON];
	assign sync_dis = ctrl_q[`GTC_CTRL_SYNC_DIS];
	// Oscillator only usable with an internal system clock
	assign osc_en   = ctrl_q[`GTC_CTRL_OSC_EN] & sys_clk_internal; // RQ6
	// Oscillator replaces the pin as external source when enabled
	assign ext_level = osc_en ? osc_sync_q[1] : ext_sync_q[1]; // RQ6
	assign rise = ext_level & ~ext_prev_q;
	assign fall = ~ext_level & ext_prev_q;

	always_comb begin
		if (ctrl_q[`GTC_CTRL_CLK_SRC])
			src = gtc_pkg::GTC_SRC_EXT; // RQ2
		else if (ctrl_q[`GTC_CTRL_ALT_CLK])
			src = gtc_pkg::GTC_SRC_SCLK; // RQ2
		else
			src = gtc_pkg::GTC_SRC_ICLK; // RQ2
	end

	// Async mode is modelled by sampled edges too, so it keeps counting
	// regardless of sleep; the one-count slip on mode switch is tolerated.
	always_comb begin
		case (src)
			gtc_pkg::GTC_SRC_ICLK: src_tick = (iclk_q == 2'd3); // RQ2
			gtc_pkg::GTC_SRC_SCLK: src_tick = 1'b1; // RQ2
			gtc_pkg::GTC_SRC_EXT:  src_tick = rise && arm_q == gtc_pkg::GTC_ARM_READY; // RQ3 RQ4 RQ9 RQ10
			default:               src_tick = 1'b0;
		endcase
	end

	assign gate_level  = ctrl_q[`GTC_CTRL_GATE_SEL] ? cmp_sync_q[1] : gpin_sync_q[1]; // RQ14
	assign gate_active = ctrl_q[`GTC_CTRL_GATE_INV] ? gate_level : ~gate_level; // RQ15 RQ16
	assign run = timer_on && (!ctrl_q[`GTC_CTRL_GATE_EN] || gate_active); // RQ16 RQ18

	function automatic logic presc_full(input logic [1:0] ps, input logic [2:0] c);
		case (gtc_pkg::gtc_ps_e'(ps))
			gtc_pkg::GTC_PS_DIV1: presc_full = 1'b1; // RQ17
			gtc_pkg::GTC_PS_DIV2: presc_full = c[0]; // RQ17
			gtc_pkg::GTC_PS_DIV4: presc_full = &c[1:0]; // RQ17
			gtc_pkg::GTC_PS_DIV8: presc_full = &c; // RQ17
			default:              presc_full = 1'b1;
		endcase
	endfunction : presc_full

	assign presc_done = presc_full(ctrl_q[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO], presc_q);
	assign inc = run && src_tick && presc_done;

	// ------------------------------------------------------------------------
	// Wishbone decode
	// ------------------------------------------------------------------------
	assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign addr_hit = wb_adr_i[31:`GTC_ADDR_W] == '0 && wb_adr_i[1:0] == 2'b00;
	assign wr_ctrl  = bus_req && wb_we_i && addr_hit
		&& wb_adr_i[`GTC_ADDR_W-1:0] == `GTC_OFF_CTRL;
	assign wr_irq   = bus_req && wb_we_i && addr_hit && wb_sel_i[0]
		&& wb_adr_i[`GTC_ADDR_W-1:0] == `GTC_OFF_IRQ;
	assign wr_low   = bus_req && wb_we_i && addr_hit && wb_sel_i[0]
		&& wb_adr_i[`GTC_ADDR_W-1:0] == `GTC_OFF_COUNT_LOW;
	assign wr_high  = bus_req && wb_we_i && addr_hit && wb_sel_i[0]
		&& wb_adr_i[`GTC_ADDR_W-1:0] == `GTC_OFF_COUNT_HIGH;
	assign wr_count = wr_low || wr_high;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= `GTC_CTRL_RESET;
		end else if (clk_en && wr_ctrl) begin
			if (wb_sel_i[0])
				ctrl_q[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				ctrl_q[`GTC_CTRL_W-1:8] <= wb_dat_i[`GTC_CTRL_W-1:8];
		end
	end

	// ------------------------------------------------------------------------
	// Instruction-clock divider and prescaler
	// ------------------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			iclk_q <= 2'd0;
		else if (clk_en)
			iclk_q <= iclk_q + 2'd1;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			presc_q <= 3'd0;
		else if (clk_en) begin
			if (wr_count)
				presc_q <= 3'd0; // RQ5
			else if (run && src_tick)
				presc_q <= presc_done ? 3'd0 : presc_q + 3'd1; // RQ5
		end
	end

	// ------------------------------------------------------------------------
	// Falling-edge arming for counter mode
	// ------------------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			arm_q           <= gtc_pkg::GTC_ARM_WAIT_FALL; // RQ4
			timer_on_prev_q <= 1'b0;
		end else if (clk_en) begin
			timer_on_prev_q <= timer_on;
			case (arm_q)
				gtc_pkg::GTC_ARM_WAIT_FALL:
					if (fall && !wr_count)
						arm_q <= gtc_pkg::GTC_ARM_READY;
				gtc_pkg::GTC_ARM_READY:
					// Re-arm on write, or on enable while the input sits low
					if (wr_count || (timer_on && !timer_on_prev_q && !ext_level))
						arm_q <= gtc_pkg::GTC_ARM_WAIT_FALL; // RQ4
				default:
					arm_q <= gtc_pkg::GTC_ARM_WAIT_FALL;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			count_q <= `GTC_COUNT_RESET;
		else if (clk_en) begin
			if (wr_low)
				count_q[7:0] <= wb_dat_i[7:0]; // RQ1 RQ24
			if (wr_high)
				count_q[15:8] <= wb_dat_i[7:0]; // RQ1 RQ24
			if (!wr_count) begin
				if (special_event_trigger)
					count_q <= `GTC_COUNT_RESET; // RQ23
				else if (inc)
					count_q <= count_q + 16'h0001; // RQ1
			end
		end
	end

	// ------------------------------------------------------------------------
	// Overflow flag, enables and interrupt
	// ------------------------------------------------------------------------
	logic overflow;
	assign overflow = inc && !wr_count && !special_event_trigger
		&& count_q == `GTC_COUNT_MAX; // RQ19 RQ23

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			irq_q <= `GTC_IRQ_RESET;
		else if (clk_en) begin
			if (wr_irq)
				irq_q <= wb_dat_i[`GTC_IRQ_W-1:0];
			// Set wins over a simultaneous software clear
			if (overflow)
				irq_q[`GTC_IRQ_FLAG] <= 1'b1; // RQ19 RQ20
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			overflow_irq      <= 1'b0;
			wake_request      <= 1'b0;
			wake_vector_taken <= 1'b0;
		end else if (clk_en) begin
			overflow_irq <= irq_q[`GTC_IRQ_FLAG] && irq_q[`GTC_IRQ_OVF_EN]
				&& irq_q[`GTC_IRQ_PERIPH_EN] && irq_q[`GTC_IRQ_GLOBAL_EN]; // RQ20
			wake_request <= sleep_mode && timer_on && sync_dis
				&& ctrl_q[`GTC_CTRL_CLK_SRC] && irq_q[`GTC_IRQ_FLAG]
				&& irq_q[`GTC_IRQ_OVF_EN] && irq_q[`GTC_IRQ_PERIPH_EN]; // RQ9 RQ21
			wake_vector_taken <= sleep_mode && timer_on && sync_dis
				&& ctrl_q[`GTC_CTRL_CLK_SRC] && irq_q[`GTC_IRQ_FLAG]
				&& irq_q[`GTC_IRQ_OVF_EN] && irq_q[`GTC_IRQ_PERIPH_EN]
				&& irq_q[`GTC_IRQ_GLOBAL_EN]; // RQ21
		end
	end

	// ------------------------------------------------------------------------
	// Capture/compare time base and oscillator pins
	// ------------------------------------------------------------------------
	logic tb_ok;
	assign tb_ok = !(ctrl_q[`GTC_CTRL_CLK_SRC] && sync_dis)
		&& !(!ctrl_q[`GTC_CTRL_CLK_SRC] && ctrl_q[`GTC_CTRL_ALT_CLK]); // RQ11

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			capture_value      <= 16'h0000;
			compare_match      <= 1'b0;
			time_base_valid    <= 1'b0;
			pin5_direction     <= 1'b0;
			pin4_direction     <= 1'b0;
			port_pin_read_mask <= 1'b0;
		end else if (clk_en) begin
			time_base_valid <= tb_ok; // RQ11
			if (capture_event && tb_ok)
				capture_value <= count_q; // RQ22
			compare_match      <= tb_ok && compare_value == count_q; // RQ22
			pin5_direction     <= osc_en; // RQ7
			pin4_direction     <= osc_en; // RQ7
			port_pin_read_mask <= osc_en; // RQ7
		end
	end

	// ------------------------------------------------------------------------
	// Bus answer: one-cycle ack, err for unmapped addresses
	// ------------------------------------------------------------------------
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i[`GTC_ADDR_W-1:0])
			`GTC_OFF_CTRL:       rd_data[`GTC_CTRL_W-1:0] = ctrl_q;
			`GTC_OFF_COUNT_LOW:  rd_data[7:0] = count_q[7:0]; // RQ12
			`GTC_OFF_COUNT_HIGH: rd_data[7:0] = count_q[15:8]; // RQ12
			`GTC_OFF_IRQ:        rd_data[`GTC_IRQ_W-1:0] = irq_q;
			default:             rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (clk_en) begin
			wb_ack_o <= bus_req && addr_hit;
			wb_err_o <= bus_req && !addr_hit;
			wb_dat_o <= (bus_req && addr_hit && !wb_we_i) ? rd_data : 32'h0000_0000;
		end
	end
endmodule : gtc_timer

// ===== test/gtc_timer_asserts.sv
/* Checker of the timer ports: bus answers, oscillator pins, interrupt, wake.
   Assumes a bind to gtc_timer and a master that always drives sel 4'hF. */
module gtc_timer_asserts (
	input logic		clock,
	input logic		sys_rst,
	input logic [31:0]	wb_adr_i,
	input logic [31:0]	wb_dat_i,
	input logic		wb_we_i,
	input logic		wb_cyc_i,
	input logic		wb_stb_i,
	input logic		sys_clk_internal,
	input logic [31:0]	wb_dat_o,
	input logic		wb_ack_o,
	input logic		wb_err_o,
	input logic		time_base_valid,
	input logic		pin5_direction,
	input logic		pin4_direction,
	input logic		port_pin_read_mask,
	input logic		overflow_irq,
	input logic		wake_request,
	input logic		wake_vector_taken
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	// ------------------------------------------------------------
	// Shadow of control and enables
	// ------------------------------------------------------------
	// Outputs lag one cycle behind, so enable checks also accept last cycle
	logic [9:0]	ctl_q;
	logic [3:0]	irq_q;
	logic		take;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) ctl_q <= 10'h000;
		else if (take && wb_we_i && wb_adr_i == 32'h0000_0000) ctl_q <= wb_dat_i[9:0];
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) irq_q <= 4'h0;
		else if (take && wb_we_i && wb_adr_i == 32'h0000_000C) irq_q <= wb_dat_i[3:0];
	end
	sequence osc_settled;
		(ctl_q[3] && sys_clk_internal) [*3];
	endsequence
	sequence single_answer;
		(wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
	endsequence
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	answer_pulse_a: assert property (take |=> single_answer)
		else $error("bus answer is not one pulse");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	unmapped_err_a: assert property (take && (wb_adr_i > 32'h0000_000C ||
		wb_adr_i[1:0] != 2'b00) |=> wb_err_o && !wb_ack_o)
		else $error("unmapped access not refused");
	osc_pins_a: assert property (osc_settled |-> pin5_direction && pin4_direction &&
		port_pin_read_mask) else $error("oscillator pins not forced");
	irq_enables_a: assert property (overflow_irq |-> &irq_q[3:1] || $past(&irq_q[3:1]))
		else $error("interrupt without all enables");
	flag_holds_a: assert property (overflow_irq && !take && !wb_ack_o |=> overflow_irq)
		else $error("interrupt dropped without software");
	wake_enables_a: assert property (wake_request |-> (ctl_q[0] && irq_q[1] && irq_q[2]) ||
		$past(ctl_q[0] && irq_q[1] && irq_q[2])) else $error("wake without enables");
	vector_global_a: assert property (wake_vector_taken |-> wake_request &&
		(irq_q[3] || $past(irq_q[3]))) else $error("vector without global enable");
	time_base_a: assert property ((ctl_q[1] ? ctl_q[2] : ctl_q[8]) [*3] |-> !time_base_valid)
		else $error("time base offered in wrong mode");
endmodule : gtc_timer_asserts

bind gtc_timer gtc_timer_asserts u_asserts (
	.clock(clock), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.sys_clk_internal(sys_clk_internal), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .time_base_valid(time_base_valid), .pin5_direction(pin5_direction),
	.pin4_direction(pin4_direction), .port_pin_read_mask(port_pin_read_mask),
	.overflow_irq(overflow_irq), .wake_request(wake_request),
	.wake_vector_taken(wake_vector_taken)
);

// ===== test/gtc_pins_model.sv
/* Far side of the timer: external count pin and free-running oscillator.
   Assumes start is a one-cycle pulse with pulses of at least one. */
module gtc_pins_model #(
	parameter int STEP	= 4,
	parameter int OSC_HALF	= 305
) (
	input logic		clock,
	input logic		sys_rst,
	input logic		start,
	input logic [7:0]	pulses,
	output logic		ext_pin,
	output logic		osc_clk
);
	logic [7:0]	left_q;
	logic [15:0]	tick_q;
	logic [15:0]	osc_q;
	// Low then high for STEP cycles each, well above the pin synchroniser
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			left_q <= 8'h00;
			tick_q <= 16'h0000;
			ext_pin <= 1'b0;
		end else if (start) begin
			left_q <= pulses;
			tick_q <= 16'h0000;
			ext_pin <= 1'b0;
		end else if (left_q != 8'h00) begin
			tick_q <= tick_q + 16'h0001;
			if (tick_q == 16'(STEP - 1)) ext_pin <= 1'b1;
			if (tick_q == 16'(2 * STEP - 1)) begin
				tick_q <= 16'h0000;
				left_q <= left_q - 8'h01;
				ext_pin <= (left_q == 8'h01);
			end
		end
	end
	// Oscillator runs free, also while the core sleeps
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			osc_q <= 16'h0000;
			osc_clk <= 1'b0;
		end else if (osc_q == 16'(OSC_HALF - 1)) begin
			osc_q <= 16'h0000;
			osc_clk <= !osc_clk;
		end else begin
			osc_q <= osc_q + 16'h0001;
		end
	end
endmodule : gtc_pins_model

// ===== test/test_gated_16bit_timer_counter.sv
/* Self-checking bench of the timer over classic Wishbone.
   Assumes the checker is bound in and the pin model drives the count input. */
module test_gated_16bit_timer_counter;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CTL = 32'h0000_0000;
	localparam logic [31:0] LO = 32'h0000_0004;
	localparam logic [31:0] HI = 32'h0000_0008;
	localparam logic [31:0] IRQ = 32'h0000_000C;
	logic		clock = 1'b0;
	logic		sys_rst = 1'b1;
	logic [31:0]	adr = 32'h0000_0000;
	logic [31:0]	wdat = 32'h0000_0000;
	logic [31:0]	rdat;
	logic		we = 1'b0;
	logic		cyc = 1'b0;
	logic		stb = 1'b0;
	logic		ack, err, ext, osc, p5, p4, pmask, oirq, wake, wvec;
	logic		gpin = 1'b0;
	logic		comp = 1'b1;
	logic		sleep = 1'b0;
	logic		cap_ev = 1'b0;
	logic		trig = 1'b0;
	logic		start = 1'b0;
	logic [7:0]	npulse = 8'h00;
	logic [15:0]	cap_val;
	logic		cmatch;
	int		bad_count = 0;
	int		checks = 0;
	int		cyc_n = 0;

	always #25 clock = !clock;

	gtc_timer DUT (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .external_count_input(ext),
		.lp_osc_clock(osc), .gate_input_pin(gpin), .comparator_output(comp),
		.sys_clk_internal(1'b1), .sleep_mode(sleep), .capture_event(cap_ev),
		.compare_value(16'h0000), .special_event_trigger(trig), .capture_value(cap_val),
		.compare_match(cmatch), .time_base_valid(), .pin5_direction(p5), .pin4_direction(p4),
		.port_pin_read_mask(pmask), .overflow_irq(oirq), .wake_request(wake),
		.wake_vector_taken(wvec));
	gtc_pins_model u_pins (.clock(clock), .sys_rst(sys_rst), .start(start),
		.pulses(npulse), .ext_pin(ext), .osc_clk(osc));

	task automatic summarize;
		if (bad_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize

	task automatic exp1(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			$display("Error %0t %s", $time, m);
			bad_count++;
		end
	endtask : exp1

	// Trigger, when asked, is seen only at the edge that takes the request
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
			input logic t, output logic [31:0] q, output logic e);
		adr <= a;
		we <= w;
		wdat <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		trig <= t;
		@(posedge clock);
		trig <= 1'b0;
		while (ack !== 1'b1 && err !== 1'b1) @(posedge clock);
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clock);
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		bus(a, 1'b1, d, 1'b0, q, e);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] q;
		logic e;
		bus(a, 1'b0, 32'h0000_0000, 1'b0, q, e);
		exp1(!$isunknown(q) && q >= lo && q <= hi, "read value");
	endtask : rd

	task automatic pulse_ext(input logic [7:0] n);
		npulse <= n;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		repeat (12 * n) @(posedge clock);
	endtask : pulse_ext

	always @(posedge clock) begin
		cyc_n++;
		if (cyc_n == 6000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		logic [31:0] q;
		logic e;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		for (int a = 0; a < 16; a += 4) rd(a, '0, '0);
		bus(32'h0000_0010, 1'b0, 32'h0000_0000, 1'b0, q, e);
		exp1(e === 1'b1, "unmapped read not refused");
		wr(LO, 32'h0000_0034);
		wr(HI, 32'h0000_0012);
		repeat (20) @(posedge clock);
		rd(LO, 32'h0000_0034, 32'h0000_0034);
		rd(HI, 32'h0000_0012, 32'h0000_0012);
		cap_ev <= 1'b1;
		@(posedge clock);
		cap_ev <= 1'b0;
		repeat (3) @(posedge clock);
		exp1(cap_val === 16'h1234, "capture value");
		trig <= 1'b1;
		@(posedge clock);
		trig <= 1'b0;
		repeat (3) @(posedge clock);
		exp1(cmatch === 1'b1, "compare match");
		rd(LO, '0, '0);
		rd(HI, '0, '0);
		rd(IRQ, '0, '0);
		bus(LO, 1'b1, 32'h0000_0056, 1'b1, q, e);
		rd(LO, 32'h0000_0056, 32'h0000_0056);
		for (int p = 0; p < 4; p++) begin
			wr(LO, '0);
			wr(CTL, 32'h0000_0001 | (p << 4));
			repeat (160) @(posedge clock);
			wr(CTL, '0);
			rd(LO, (40 >> p) - 1, (40 >> p) + 1);
		end
		wr(LO, '0);
		wr(CTL, 32'h0000_0101);
		repeat (160) @(posedge clock);
		wr(CTL, '0);
		rd(LO, 32'h0000_009E, 32'h0000_00A6);
		// Gate low, comparator high: only matching polarity may count
		for (int i = 0; i < 4; i++) begin
			wr(LO, '0);
			wr(CTL, 32'h0000_0141 | (i[0] << 7) | (i[1] << 9));
			repeat (40) @(posedge clock);
			wr(CTL, '0);
			if (i == 0 || i == 3) rd(LO, 32'h0000_001E, 32'h0000_0032);
			else rd(LO, '0, '0);
		end
		wr(CTL, 32'h0000_0008);
		repeat (4) @(posedge clock);
		exp1(p5 === 1'b1 && p4 === 1'b1 && pmask === 1'b1, "oscillator pins");
		wr(CTL, '0);
		wr(LO, '0);
		wr(CTL, 32'h0000_0003);
		pulse_ext(8'h05);
		rd(LO, 32'h0000_0004, 32'h0000_0004);
		wr(CTL, '0);
		wr(LO, 32'h0000_00FE);
		wr(HI, 32'h0000_00FF);
		wr(IRQ, 32'h0000_0006);
		sleep <= 1'b1;
		wr(CTL, 32'h0000_0007);
		pulse_ext(8'h03);
		exp1(wake === 1'b1 && oirq === 1'b0 && wvec === 1'b0, "wake in sleep");
		sleep <= 1'b0;
		rd(LO, 32'h0000_0001, 32'h0000_0001);
		rd(HI, '0, '0);
		rd(IRQ, 32'h0000_0007, 32'h0000_0007);
		wr(IRQ, 32'h0000_000F);
		repeat (2) @(posedge clock);
		exp1(oirq === 1'b1, "interrupt with all enables");
		wr(IRQ, 32'h0000_000E);
		repeat (2) @(posedge clock);
		exp1(oirq === 1'b0, "interrupt after clear");
		summarize();
	end
endmodule : test_gated_16bit_timer_counter
